/* File: hdl/ndc_loader.sv */
`timescale 1ns/1ns
module ndc_loader
	import ndc_pkg::*;
#(
	parameter bit DUAL_ROLE_VARIANT = 1'b0,
	parameter logic [15:0] CUSTOMER_PASSWORD = 16'h5A5A
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire ndc_reg_req_t reg_req,
	output logic reg_ack,
	output logic [7:0] reg_rdata,
	output logic nvm_rd_en,
	output logic nvm_wr_en,
	output logic [3:0] nvm_addr,
	output logic [7:0] nvm_wdata,
	input wire logic [7:0] nvm_rdata,
	input wire logic nvm_done,
	input wire logic prog_start,
	input wire logic [15:0] prog_password,
	input wire logic [71:0] prog_image,
	output logic prog_done,
	output logic prog_refused,
	output logic load_done,
	input wire logic sink_role_pin,
	output ndc_cfg_t cfg
);

	// ----------------------------------------
	// Helper functions.
	// ----------------------------------------

	// Maps a register offset onto a slot; unmapped offsets give IDX_NONE.
	function automatic logic [3:0] slot_of(input logic [7:0] addr);
		case (addr)
			ADDR_ALERT_INTERRUPT_MASK: slot_of = IDX_MASK;
			ADDR_CONNECTOR_CAPABILITY_CONTROL: slot_of = IDX_CAP;
			ADDR_SUPPLY_SWITCH_CURRENT_LIMIT: slot_of = IDX_ILIM;
			ADDR_CONNECTOR_SUPPLY_MONITOR_CONTROL: slot_of = IDX_MON;
			ADDR_BUS_VOLTAGE_RANGE_CONTROL: slot_of = IDX_RANGE;
			ADDR_SOFTWARE_RESET_CONTROL: slot_of = IDX_RST;
			ADDR_BUS_DISCHARGE_TIME_CONTROL: slot_of = IDX_DISCH;
			ADDR_PORT_POWER_MODE_CONTROL: slot_of = IDX_MODE;
			ADDR_BUS_MONITOR_CONTROL: slot_of = IDX_BUSMON;
			default: slot_of = IDX_NONE;
		endcase
	endfunction

	// Reset value of each slot.
	function automatic logic [7:0] reset_of(input logic [3:0] idx);
		case (idx)
			IDX_MASK: reset_of = RST_MASK;
			IDX_CAP: reset_of = DUAL_ROLE_VARIANT ? RST_CAP_DUAL : RST_CAP_BASE;
			IDX_ILIM: reset_of = RST_ILIM;
			IDX_MON: reset_of = RST_MON;
			IDX_RANGE: reset_of = RST_RANGE_SRC;
			IDX_RST: reset_of = RST_RST;
			IDX_DISCH: reset_of = RST_DISCH;
			IDX_MODE: reset_of = RST_MODE;
			IDX_BUSMON: reset_of = RST_BUSMON;
			default: reset_of = LOAD_NONE;
		endcase
	endfunction

	// Bits of each slot that the store may overwrite during the load.
	function automatic logic [7:0] load_mask_of(input logic [3:0] idx);
		case (idx)
			IDX_MON: load_mask_of = LOAD_NONE;
			IDX_RST: load_mask_of = LOAD_NONE;
			default: load_mask_of = LOAD_ALL;
		endcase
	endfunction

	// ----------------------------------------
	// Storage and state.
	// ----------------------------------------
	logic [7:0] slot_reg [NUM_SLOTS]; // Register file, one byte per slot.
	logic [7:0] slot_next [NUM_SLOTS]; // Next value of the register file.
	logic [7:0] sink_pair_reg; // Consumer offsets, shown at 22h in sink role.
	logic [7:0] sink_pair_next; // Next consumer offsets.
	logic [7:0] misc_reg; // Store-only bits and the one-time lock.
	logic [7:0] misc_next; // Next store-only bits.
	ndc_state_t state_reg; // Controller state.
	ndc_state_t state_next; // Next controller state.
	logic [3:0] ptr_reg; // Store byte being read or written.
	logic [3:0] ptr_next; // Next store pointer.
	logic ack_reg; // Register access answered.
	logic ack_next; // Next answer strobe.
	logic [7:0] rdata_reg; // Read data of the register port.
	logic [7:0] rdata_next; // Next read data.
	logic done_reg; // Programming accepted and finished.
	logic done_next; // Next programming done strobe.
	logic refused_reg; // Programming attempt refused.
	logic refused_next; // Next refusal strobe.
	logic sink_meta_reg; // First synchroniser stage of the role pin.
	logic sink_role_reg; // Synchronised role pin.
	logic [3:0] req_slot; // Slot addressed by the pending request.
	logic [7:0] image_byte; // Image byte at the current pointer.

	assign req_slot = slot_of(reg_req.addr);
	assign image_byte = prog_image[ptr_reg*8 +: 8];

	// ----------------------------------------
	// Next-state logic for the loader, programmer and register port.
	// ----------------------------------------

	// Computes every next value; the clocked process only registers them.
	always_comb begin
		slot_next = slot_reg;
		sink_pair_next = sink_pair_reg;
		misc_next = misc_reg;
		state_next = state_reg;
		ptr_next = ptr_reg;
		ack_next = 1'b0;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		refused_next = 1'b0;
		nvm_rd_en = 1'b0;
		nvm_wr_en = 1'b0;
		nvm_addr = ptr_reg;
		nvm_wdata = image_byte;
		case (state_reg)
			CTL_LOAD_REQ: begin
				// Ask the store for the byte at the pointer.
				nvm_rd_en = 1'b1;
				state_next = CTL_LOAD_WAIT;
			end
			CTL_LOAD_WAIT: begin
				// Merge the returned byte into its slot.
				if (nvm_done) begin
					if (ptr_reg == NVM_SINK_PAIR) begin
						sink_pair_next = nvm_rdata;
					end else if (ptr_reg == NVM_MISC) begin
						misc_next = nvm_rdata;
					end else begin
						slot_next[ptr_reg] = (slot_reg[ptr_reg] & ~load_mask_of(ptr_reg)) |
							(nvm_rdata & load_mask_of(ptr_reg));
					end
					if (ptr_reg == 4'(NUM_SLOTS - 1)) begin
						ptr_next = 4'h0;
						state_next = CTL_READY;
					end else begin
						ptr_next = ptr_reg + 4'h1;
						state_next = CTL_LOAD_REQ;
					end
				end
			end
			CTL_READY: begin
				if (prog_start) begin
					// One successful programming only, and only with the right password.
					if (misc_reg[POS_LOCK] || prog_password != CUSTOMER_PASSWORD) begin
						refused_next = 1'b1;
					end else begin
						ptr_next = 4'h0;
						state_next = CTL_PROG_REQ;
					end
				end else if (reg_req.req) begin
					// Register accesses are answered only once loaded.
					ack_next = 1'b1;
					rdata_next = 8'h00;
					if (req_slot == IDX_RANGE && sink_role_reg) begin
						rdata_next = sink_pair_reg;
						if (reg_req.wr) begin
							sink_pair_next = reg_req.wdata;
						end
					end else if (req_slot != IDX_NONE) begin
						rdata_next = slot_reg[req_slot];
						if (reg_req.wr) begin
							slot_next[req_slot] = reg_req.wdata;
						end
					end
				end
			end
			CTL_PROG_REQ: begin
				// Write one image byte; the lock bit is forced into the misc byte.
				nvm_wr_en = 1'b1;
				if (ptr_reg == NVM_MISC) begin
					nvm_wdata = image_byte | (8'h01 << POS_LOCK);
				end
				state_next = CTL_PROG_WAIT;
			end
			CTL_PROG_WAIT: begin
				// Live registers are left alone; new defaults apply after reset.
				if (nvm_done) begin
					if (ptr_reg == 4'(NUM_SLOTS - 1)) begin
						ptr_next = 4'h0;
						misc_next[POS_LOCK] = 1'b1;
						done_next = 1'b1;
						state_next = CTL_READY;
					end else begin
						ptr_next = ptr_reg + 4'h1;
						state_next = CTL_PROG_REQ;
					end
				end
			end
			default: begin
				state_next = CTL_LOAD_REQ;
				ptr_next = 4'h0;
			end
		endcase
	end

	// ----------------------------------------
	// Registers.
	// ----------------------------------------

	// Reset restores the documented defaults and restarts the load.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slot_reg[i] <= reset_of(4'(i));
			end
			sink_pair_reg <= RST_RANGE_SNK;
			misc_reg <= RST_MISC;
			state_reg <= CTL_LOAD_REQ;
			ptr_reg <= 4'h0;
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			slot_reg <= slot_next;
			sink_pair_reg <= sink_pair_next;
			misc_reg <= misc_next;
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
			refused_reg <= refused_next;
		end
	end

	// Two-stage synchroniser for the role pin.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sink_meta_reg <= 1'b0;
			sink_role_reg <= 1'b0;
		end else begin
			sink_meta_reg <= sink_role_pin;
			sink_role_reg <= sink_meta_reg;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign reg_ack = ack_reg;
	assign reg_rdata = rdata_reg;
	assign prog_done = done_reg;
	assign prog_refused = refused_reg;
	assign load_done = (state_reg != CTL_LOAD_REQ) && (state_reg != CTL_LOAD_WAIT);

	// Spreads the register slots onto the configuration fields.
	always_comb begin
		cfg.attach_change_alert_mask = slot_reg[IDX_MASK][POS_ATTACH_MASK];
		cfg.voltage_monitor_alert_mask = slot_reg[IDX_MASK][POS_VOLTAGE_MASK];
		cfg.fault_alert_mask = slot_reg[IDX_MASK][POS_FAULT_MASK];
		cfg.advertised_current_level = slot_reg[IDX_CAP][POS_CUR_LO +: 2];
		cfg.plug_supply_drain_enable = slot_reg[IDX_CAP][POS_DRAIN_EN];
		cfg.plug_supply_capability_enable = slot_reg[IDX_CAP][POS_CAPAB_EN];
		cfg.current_limit_code = slot_reg[IDX_ILIM][3:0];
		cfg.plug_supply_undervoltage_watch = slot_reg[IDX_MON][POS_UV_WATCH];
		cfg.plug_supply_undervoltage_level = slot_reg[IDX_MON][POS_UV_LEVEL];
		cfg.provider_upper_limit_offset = slot_reg[IDX_RANGE][7:4];
		cfg.provider_lower_limit_offset = slot_reg[IDX_RANGE][3:0];
		cfg.consumer_upper_limit_offset = sink_pair_reg[7:4];
		cfg.consumer_lower_limit_offset = sink_pair_reg[3:0];
		cfg.software_initiated_reset = slot_reg[IDX_RST][POS_SW_RESET];
		cfg.drain_to_zero_duration = slot_reg[IDX_DISCH][7:4];
		cfg.drain_on_step_duration = slot_reg[IDX_DISCH][3:0];
		cfg.port_role_select = slot_reg[IDX_MODE][2:0];
		cfg.main_supply_overvoltage_inhibit = slot_reg[IDX_BUSMON][POS_OV_INHIBIT];
		cfg.bus_window_check_inhibit = slot_reg[IDX_BUSMON][POS_WINDOW_INHIBIT];
		cfg.bus_safe_zero_level = slot_reg[IDX_BUSMON][POS_SAFE0_LO +: 2];
		cfg.main_supply_undervoltage_inhibit = slot_reg[IDX_BUSMON][POS_UV_INHIBIT];
		cfg.standby_mode_inhibit = misc_reg[POS_STANDBY_OFF];
		cfg.bus_drain_inhibit = misc_reg[POS_DRAIN_INHIBIT];
	end

endmodule

/* File: hdl/ndc_pkg.sv */
package ndc_pkg;

	// ----------------------------------------
	// Register offsets on the register port.
	// ----------------------------------------
	localparam logic [7:0] ADDR_ALERT_INTERRUPT_MASK = 8'h0C;
	localparam logic [7:0] ADDR_CONNECTOR_CAPABILITY_CONTROL = 8'h18;
	localparam logic [7:0] ADDR_SUPPLY_SWITCH_CURRENT_LIMIT = 8'h1E;
	localparam logic [7:0] ADDR_CONNECTOR_SUPPLY_MONITOR_CONTROL = 8'h20;
	localparam logic [7:0] ADDR_BUS_VOLTAGE_RANGE_CONTROL = 8'h22;
	localparam logic [7:0] ADDR_SOFTWARE_RESET_CONTROL = 8'h23;
	localparam logic [7:0] ADDR_BUS_DISCHARGE_TIME_CONTROL = 8'h25;
	localparam logic [7:0] ADDR_PORT_POWER_MODE_CONTROL = 8'h28;
	localparam logic [7:0] ADDR_BUS_MONITOR_CONTROL = 8'h2E;

	// ----------------------------------------
	// Slot indices of the register file, also the store byte addresses.
	// ----------------------------------------
	localparam int NUM_SLOTS = 9;
	localparam logic [3:0] IDX_MASK = 4'h0;
	localparam logic [3:0] IDX_CAP = 4'h1;
	localparam logic [3:0] IDX_ILIM = 4'h2;
	localparam logic [3:0] IDX_MON = 4'h3;
	localparam logic [3:0] IDX_RANGE = 4'h4;
	localparam logic [3:0] IDX_RST = 4'h5;
	localparam logic [3:0] IDX_DISCH = 4'h6;
	localparam logic [3:0] IDX_MODE = 4'h7;
	localparam logic [3:0] IDX_BUSMON = 4'h8;
	localparam logic [3:0] IDX_NONE = 4'hF;
	// Store bytes that stand in the slots of software-only registers.
	localparam logic [3:0] NVM_SINK_PAIR = IDX_MON;
	localparam logic [3:0] NVM_MISC = IDX_RST;

	// ----------------------------------------
	// Field positions.
	// ----------------------------------------
	localparam int POS_ATTACH_MASK = 4;
	localparam int POS_VOLTAGE_MASK = 5;
	localparam int POS_FAULT_MASK = 6;
	localparam int POS_CUR_LO = 6;
	localparam int POS_DRAIN_EN = 1;
	localparam int POS_CAPAB_EN = 0;
	localparam int POS_UV_WATCH = 0;
	localparam int POS_UV_LEVEL = 1;
	localparam int POS_SW_RESET = 0;
	localparam int POS_UV_INHIBIT = 7;
	localparam int POS_OV_INHIBIT = 6;
	localparam int POS_WINDOW_INHIBIT = 5;
	localparam int POS_SAFE0_LO = 1;
	localparam int POS_STANDBY_OFF = 0;
	localparam int POS_DRAIN_INHIBIT = 1;
	localparam int POS_LOCK = 7;

	// ----------------------------------------
	// Reset values and store-loadable bits of each slot.
	// ----------------------------------------
	localparam logic [7:0] RST_MASK = 8'h70;
	localparam logic [7:0] RST_CAP_BASE = 8'h01;
	localparam logic [7:0] RST_CAP_DUAL = 8'h41;
	localparam logic [7:0] RST_ILIM = 8'h00;
	localparam logic [7:0] RST_MON = 8'h01;
	localparam logic [7:0] RST_RANGE_SRC = 8'h75;
	localparam logic [7:0] RST_RANGE_SNK = 8'h7F;
	localparam logic [7:0] RST_RST = 8'h00;
	localparam logic [7:0] RST_DISCH = 8'hAA;
	localparam logic [7:0] RST_MODE = 8'h03;
	localparam logic [7:0] RST_BUSMON = 8'h80;
	localparam logic [7:0] RST_MISC = 8'h01;
	localparam logic [7:0] LOAD_ALL = 8'hFF;
	localparam logic [7:0] LOAD_NONE = 8'h00;

	// Controller states.
	typedef enum logic [4:0] {
		CTL_LOAD_REQ = 5'b0_0001,
		CTL_LOAD_WAIT = 5'b0_0010,
		CTL_READY = 5'b0_0100,
		CTL_PROG_REQ = 5'b0_1000,
		CTL_PROG_WAIT = 5'b1_0000
	} ndc_state_t;

	// Request from the serial slave to the register file.
	typedef struct packed {
		logic req;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ndc_reg_req_t;

	// Configuration levels handed to the rest of the device.
	typedef struct packed {
		logic attach_change_alert_mask;
		logic voltage_monitor_alert_mask;
		logic fault_alert_mask;
		logic [1:0] advertised_current_level;
		logic plug_supply_drain_enable;
		logic plug_supply_capability_enable;
		logic [3:0] current_limit_code;
		logic plug_supply_undervoltage_watch;
		logic plug_supply_undervoltage_level;
		logic [3:0] provider_upper_limit_offset;
		logic [3:0] provider_lower_limit_offset;
		logic [3:0] consumer_upper_limit_offset;
		logic [3:0] consumer_lower_limit_offset;
		logic software_initiated_reset;
		logic [3:0] drain_to_zero_duration;
		logic [3:0] drain_on_step_duration;
		logic [2:0] port_role_select;
		logic main_supply_overvoltage_inhibit;
		logic bus_window_check_inhibit;
		logic [1:0] bus_safe_zero_level;
		logic main_supply_undervoltage_inhibit;
		logic standby_mode_inhibit;
		logic bus_drain_inhibit;
	} ndc_cfg_t;

endpackage

/* File: testbench/ndc_loader_props.sv */
`timescale 1ns/1ns
// Checker of the register port, the store load and the reset defaults.
module ndc_loader_props
	import ndc_pkg::*;
#(
	parameter bit DUAL_ROLE_VARIANT = 1'b0,
	parameter logic [15:0] CUSTOMER_PASSWORD = 16'h5A5A
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire ndc_reg_req_t reg_req,
	input wire logic reg_ack,
	input wire logic nvm_rd_en,
	input wire logic nvm_wr_en,
	input wire logic [3:0] nvm_addr,
	input wire logic prog_start,
	input wire logic [15:0] prog_password,
	input wire logic prog_done,
	input wire logic prog_refused,
	input wire logic load_done,
	input wire ndc_cfg_t cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_ack_one_cycle: assert property (reg_req.req && load_done && !prog_start |=> reg_ack)
		else $error("register request not answered in one cycle");
	a_ack_has_cause: assert property (reg_ack |-> $past(reg_req.req) && $past(load_done))
		else $error("register answer without a taken request");
	a_mask_reset: assert property (disable iff (1'b0) sys_rst |=> cfg.attach_change_alert_mask &&
		cfg.voltage_monitor_alert_mask && cfg.fault_alert_mask)
		else $error("alert masks not set by reset");
	a_plug_reset: assert property (disable iff (1'b0) sys_rst |=> cfg.plug_supply_undervoltage_watch &&
		!cfg.plug_supply_undervoltage_level && !cfg.software_initiated_reset && cfg.current_limit_code == 4'h0 &&
		!cfg.plug_supply_drain_enable && cfg.plug_supply_capability_enable)
		else $error("plug supply fields wrong after reset");
	a_limit_reset: assert property (disable iff (1'b0) sys_rst |=> cfg.provider_upper_limit_offset == 4'h7 &&
		cfg.provider_lower_limit_offset == 4'h5 && cfg.consumer_upper_limit_offset == 4'h7 &&
		cfg.consumer_lower_limit_offset == 4'hF && cfg.drain_to_zero_duration == 4'hA &&
		cfg.drain_on_step_duration == 4'hA && cfg.port_role_select == 3'h3)
		else $error("limit, duration or role fields wrong after reset");
	a_misc_reset: assert property (disable iff (1'b0) sys_rst |=> cfg.standby_mode_inhibit &&
		cfg.advertised_current_level == (DUAL_ROLE_VARIANT ? 2'b01 : 2'b00) &&
		!cfg.main_supply_overvoltage_inhibit && !cfg.bus_window_check_inhibit &&
		cfg.bus_safe_zero_level == 2'b00 && cfg.main_supply_undervoltage_inhibit)
		else $error("supply or current fields wrong after reset");
	a_sw_field_hold: assert property ($changed(cfg.plug_supply_undervoltage_watch) ||
		$changed(cfg.software_initiated_reset) |-> $past(reg_req.req) && $past(reg_req.wr))
		else $error("software-only field changed without a write");
	a_prog_live_stable: assert property (nvm_wr_en || prog_done |-> $stable(cfg))
		else $error("programming changed a live field");
	a_bad_password: assert property (prog_start && load_done && prog_password != CUSTOMER_PASSWORD |=>
		##[0:1] prog_refused && !nvm_wr_en)
		else $error("wrong password not refused");
	a_load_order: assert property ($rose(load_done) |-> $past(nvm_addr) == 4'h8 && !nvm_rd_en)
		else $error("load finished before the last store byte");
endmodule

bind ndc_loader ndc_loader_props #(.DUAL_ROLE_VARIANT(DUAL_ROLE_VARIANT), .CUSTOMER_PASSWORD(CUSTOMER_PASSWORD))
	i_ndc_loader_props (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_ack(reg_ack),
	.nvm_rd_en(nvm_rd_en), .nvm_wr_en(nvm_wr_en), .nvm_addr(nvm_addr), .prog_start(prog_start),
	.prog_password(prog_password), .prog_done(prog_done), .prog_refused(prog_refused),
	.load_done(load_done), .cfg(cfg));

/* File: testbench/ndc_nvm_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// One-time default store model.
// ----------------------------------------
// Keeps its bytes across resets and answers after one or three cycles.
module ndc_nvm_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic done
);
	logic [7:0] mem [0:8] = '{8'h70, 8'h01, 8'h00, 8'h7F, 8'h75, 8'h01, 8'hAA, 8'h03, 8'h80}; // Factory bytes.
	logic [1:0] cnt = 2'h0; // Cycles left of the access in progress.
	logic [3:0] a_q = 4'h0; // Byte address of that access.
	logic wr_q = 1'b0; // The access is a write.
	logic [7:0] wd_q = 8'h00; // Byte to be written.
	initial rdata = 8'h00;
	initial done = 1'b0;

	// The data line toggles in every cycle but the answer cycle of a read, so stale data is never mistaken for valid.
	always @(posedge clk) begin
		done <= 1'b0;
		rdata <= ~rdata;
		if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				done <= 1'b1;
				if (wr_q) begin
					mem[a_q] <= wd_q;
				end else begin
					rdata <= mem[a_q];
				end
			end
		end else if (rd_en || wr_en) begin
			cnt <= slow ? 2'h3 : 2'h1;
			a_q <= addr;
			wr_q <= wr_en;
			wd_q <= wdata;
		end
	end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import ndc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slow = 1'b0; // Store answers slowly when set.
	logic sink = 1'b0; // Role pin.
	ndc_reg_req_t req = '0;
	logic prog_start = 1'b0;
	logic [15:0] prog_password = 16'h0000;
	logic reg_ack, nvm_rd_en, nvm_wr_en, nvm_done, prog_done, prog_refused, load_done;
	logic [7:0] reg_rdata, nvm_wdata, nvm_rdata, d;
	logic [3:0] nvm_addr;
	ndc_cfg_t cfg;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] ad [9] = '{8'h0C, 8'h18, 8'h1E, 8'h20, 8'h22, 8'h23, 8'h25, 8'h28, 8'h2E}; // Mapped offsets.
	logic [7:0] ex0 [9] = '{8'h70, 8'h01, 8'h00, 8'h01, 8'h75, 8'h00, 8'hAA, 8'h03, 8'h80}; // Factory values.
	logic [7:0] ex1 [9] = '{8'h00, 8'h42, 8'h05, 8'h01, 8'h75, 8'h00, 8'hAA, 8'h03, 8'h40}; // Programmed values.
	localparam logic [71:0] IMG = 72'h40_03AA_0275_7F05_4200; // New store image.

	always #10 clk = ~clk;

	ndc_loader #(.DUAL_ROLE_VARIANT(1'b0)) i_ndc_loader (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .nvm_rd_en(nvm_rd_en), .nvm_wr_en(nvm_wr_en),
		.nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_done(nvm_done),
		.prog_start(prog_start), .prog_password(prog_password), .prog_image(IMG), .prog_done(prog_done),
		.prog_refused(prog_refused), .load_done(load_done), .sink_role_pin(sink), .cfg(cfg));
	ndc_nvm_model i_ndc_nvm_model (.clk(clk), .slow(slow), .rd_en(nvm_rd_en), .wr_en(nvm_wr_en),
		.addr(nvm_addr), .wdata(nvm_wdata), .rdata(nvm_rdata), .done(nvm_done));

	// Ends the run with the counts and the verdict.
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Resets the block and waits for the store copy to finish.
	task automatic do_reset(input logic s);
		int i;
		@(posedge clk);
		sys_rst <= 1'b1;
		slow <= s;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (load_done !== 1'b1 && i < 400);
		if (i >= 400) begin
			errors++;
			print_verdict();
		end
	endtask

	// One register access; the request is held until the block can take it.
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
		int i;
		i = 0;
		@(posedge clk);
		req <= '{1'b1, wr, a, wd};
		do begin
			@(posedge clk);
			i++;
		end while (load_done !== 1'b1 && i < 400);
		if (i >= 400) begin
			errors++;
			print_verdict();
		end
		req.req <= 1'b0;
		@(posedge clk);
		check("ack", {7'h0, reg_ack}, 8'h01);
		rd = reg_rdata;
	endtask

	// Asks for programming; result bit 1 is refused, bit 0 is done.
	task automatic prog_store(input logic [15:0] pw, output logic [7:0] res);
		int i;
		@(posedge clk);
		prog_start <= 1'b1;
		prog_password <= pw;
		@(posedge clk);
		prog_start <= 1'b0;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (prog_done !== 1'b1 && prog_refused !== 1'b1 && i < 400);
		if (i >= 400) begin
			errors++;
			print_verdict();
		end
		res = {6'h0, prog_refused, prog_done};
	endtask

	initial begin
		do_reset(1'b0);
		foreach (ad[k]) begin
			access(1'b0, ad[k], 8'h00, d);
			check($sformatf("reg %h", ad[k]), d, ex0[k]);
		end
		check("standby", {7'h0, cfg.standby_mode_inhibit}, 8'h01);
		check("drain inhibit", {7'h0, cfg.bus_drain_inhibit}, 8'h00);
		access(1'b1, 8'h19, 8'hFF, d);
		access(1'b0, 8'h19, 8'h00, d);
		check("unmapped", d, 8'h00);
		access(1'b1, 8'h18, 8'h42, d);
		access(1'b0, 8'h18, 8'h00, d);
		check("reg 18", d, 8'h42);
		check("current", {6'h0, cfg.advertised_current_level}, 8'h01);
		access(1'b1, 8'h20, 8'h02, d);
		access(1'b0, 8'h20, 8'h00, d);
		check("reg 20", d, 8'h02);
		sink <= 1'b1;
		repeat (4) @(posedge clk);
		access(1'b0, 8'h22, 8'h00, d);
		check("consumer pair", d, 8'h7F);
		sink <= 1'b0;
		do_reset(1'b1);
		access(1'b0, 8'h18, 8'h00, d);
		check("reg 18 restored", d, 8'h01);
		access(1'b0, 8'h20, 8'h00, d);
		check("reg 20 restored", d, 8'h01);
		prog_store(16'h1234, d);
		check("bad password", d, 8'h02);
		prog_store(16'h5A5A, d);
		check("programming", d, 8'h01);
		access(1'b0, 8'h18, 8'h00, d);
		check("live reg 18", d, 8'h01);
		prog_store(16'h5A5A, d);
		check("second programming", d, 8'h02);
		do_reset(1'b0);
		foreach (ad[k]) begin
			access(1'b0, ad[k], 8'h00, d);
			check($sformatf("new reg %h", ad[k]), d, ex1[k]);
		end
		check("new standby", {7'h0, cfg.standby_mode_inhibit}, 8'h00);
		check("new drain inhibit", {7'h0, cfg.bus_drain_inhibit}, 8'h01);
		prog_store(16'h5A5A, d);
		check("locked", d, 8'h02);
		print_verdict();
	end
endmodule
